/* include/nand_host_pkg.sv */
// package: command codes, strobe timing and request encodings for the host
package nand_host_pkg;
	// ==========================================================
	// timing, clock at 250 MHz
	localparam int CLK_NS         = 4;
	localparam int STROBE_LOW_NS  = 25;  // strobe low time, also data sample
	localparam int STROBE_HIGH_NS = 15;  // strobe high time between cycles
	localparam int BUSY_SETTLE_NS = 100; // wait before ready/busy is trusted
	// least times round up to whole cycles
	localparam logic [7:0] LOW_CYC  =
		8'((STROBE_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] HIGH_CYC =
		8'((STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] WB_CYC   =
		8'((BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] CYC_LAST = LOW_CYC + HIGH_CYC - 8'h01;

	// ==========================================================
	// bus layout
	localparam int         IO_W      = 16;
	localparam int         BYTE_W    = 8;
	localparam int         IDX_W     = 3;
	localparam logic [2:0] ROW_START = 3'h2; // first row address cycle

	// ==========================================================
	// command codes
	localparam logic [7:0] CMD_READ        = 8'h00;
	localparam logic [7:0] CONF_READ       = 8'h30;
	localparam logic [7:0] CONF_COPY       = 8'h35;
	localparam logic [7:0] CONF_COPY_SP    = 8'h36;
	localparam logic [7:0] CMD_CACHE       = 8'h31;
	localparam logic [7:0] CMD_CACHE_END   = 8'h3f;
	localparam logic [7:0] CMD_PROG        = 8'h80;
	localparam logic [7:0] CMD_PROG2_TRAD  = 8'h81;
	localparam logic [7:0] CMD_COPY        = 8'h85;
	localparam logic [7:0] CONF_PROG       = 8'h10;
	localparam logic [7:0] CONF_PROG_CACHE = 8'h15;
	localparam logic [7:0] CONF_PLANE      = 8'h11;
	localparam logic [7:0] CMD_ERASE       = 8'h60;
	localparam logic [7:0] CONF_ERASE      = 8'hd0;
	localparam logic [7:0] CONF_ERASE_PL   = 8'hd1;
	localparam logic [7:0] CMD_STATUS      = 8'h70;
	localparam logic [7:0] CMD_STATUS_ENH  = 8'h78;
	localparam logic [7:0] CMD_RESET       = 8'hff;

	// ==========================================================
	// request encodings
	typedef enum logic [3:0] {
		op_read, op_read_copy, op_read_copy_sp, op_cache_rand,
		op_cache_seq, op_cache_end, op_prog, op_prog2_trad,
		op_copy_prog, op_erase, op_status, op_status_enh, op_reset
	} op_e;
	typedef enum logic [1:0] {fin_end, fin_cache, fin_plane, fin_none} fin_e;
endpackage

/* rtl/addr_cycle_fmt.sv */
// address cycle formatter: column and row into one registered bus word
`timescale 1ns/1ps
module addr_cycle_fmt #(
	parameter int COL_W = 12,
	parameter int ROW_W = 19
) (
	input  wire logic                            core_clk,
	input  wire logic                            srst,
	input  wire logic [nand_host_pkg::IDX_W-1:0] idx,
	input  wire logic                            x16,
	input  wire logic [COL_W-1:0]                col,
	input  wire logic [ROW_W-1:0]                row,
	output logic      [nand_host_pkg::IO_W-1:0]  word_reg
);
	// ==========================================================
	// cycle select
	logic [nand_host_pkg::IO_W-1:0] word_next;
	logic [23:0]                    row_w;

	// unused positions are forced low, upper lines always low
	always_comb begin
		row_w     = 24'(row);
		word_next = '0;
		case (idx)
			3'h0: word_next[7:0] = col[7:0];
			3'h1: begin
				if (x16) begin
					word_next[2:0] = col[10:8];
				end else begin
					word_next[3:0] = col[11:8];
				end
			end
			3'h2: word_next[7:0] = row_w[7:0];
			3'h3: word_next[7:0] = row_w[15:8];
			3'h4: word_next[7:0] = row_w[23:16];
			default: word_next = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			word_reg <= '0;
		end else begin
			word_reg <= word_next;
		end
	end

	// ==========================================================
	// checks
	chk_col_upper_low: assert property (@(posedge core_clk) disable iff (srst)
		idx == 3'h1 && !x16 |=> word_reg[15:4] == '0)
		else $error("second column cycle drives upper lines");
	chk_x16_col_low: assert property (@(posedge core_clk) disable iff (srst)
		idx == 3'h1 && x16 |=> word_reg[15:3] == '0)
		else $error("x16 column cycle drives unused bits");
endmodule

/* rtl/nand_host_ctrl.sv */
// host controller that drives the flash pins for one request at a time
// Function
// - two column cycles, upper second-cycle bits low
// - host drives unused address bits low
// - five address cycles, three row cycles
// - read 00h then 30h, 35h, 36h
// - program 80h, confirm 10h or 15h
// - multi-plane program 80h, 11h, 81h/80h, confirm
// - multi-plane copy 85h, 11h, 81h/85h, 10h
// - erase 60h, D0h, multi-plane 60h or D1h
// - cache read 31h, random 00h-31h, end 3Fh
// - host holds both strobes high while busy
`timescale 1ns/1ps
module nand_host_ctrl #(
	parameter int ADDR_CYCLES = 5,
	parameter int COL_W       = 12,
	parameter int ROW_W       = 19,
	parameter int LEN_W       = 13
) (
	input  wire logic                           core_clk,
	input  wire logic                           srst,
	input  wire logic                           req_valid,
	output logic                                req_ready_reg,
	input  wire nand_host_pkg::op_e             req_op,
	input  wire nand_host_pkg::fin_e            req_fin,
	input  wire logic [COL_W-1:0]               req_col,
	input  wire logic [ROW_W-1:0]               req_row,
	input  wire logic [LEN_W-1:0]               req_len,
	input  wire logic                           bus_x16,
	input  wire logic                           wp_release,
	input  wire logic [nand_host_pkg::IO_W-1:0] wr_data,
	input  wire logic                           wr_valid,
	output logic                                wr_take_reg,
	output logic      [nand_host_pkg::IO_W-1:0] rd_data_reg,
	output logic                                rd_valid_reg,
	output logic                                done_reg,
	output logic                                cle_reg,
	output logic                                ale_reg,
	output logic                                ce_n_reg,
	output logic                                we_n_reg,
	output logic                                read_strobe_n_reg,
	output logic                                wp_n_reg,
	output logic      [nand_host_pkg::IO_W-1:0] io_out_reg,
	output logic                                io_oe_reg,
	input  wire logic [nand_host_pkg::IO_W-1:0] io_in,
	input  wire logic                           rb_n_in
);
	// ==========================================================
	// request decoding
	function automatic logic [7:0] code1(input nand_host_pkg::op_e op);
		case (op)
			nand_host_pkg::op_cache_seq:  code1 = nand_host_pkg::CMD_CACHE;
			nand_host_pkg::op_cache_end:  code1 = nand_host_pkg::CMD_CACHE_END;
			nand_host_pkg::op_prog:       code1 = nand_host_pkg::CMD_PROG;
			nand_host_pkg::op_prog2_trad: code1 = nand_host_pkg::CMD_PROG2_TRAD;
			nand_host_pkg::op_copy_prog:  code1 = nand_host_pkg::CMD_COPY;
			nand_host_pkg::op_erase:      code1 = nand_host_pkg::CMD_ERASE;
			nand_host_pkg::op_status:     code1 = nand_host_pkg::CMD_STATUS;
			nand_host_pkg::op_status_enh: code1 = nand_host_pkg::CMD_STATUS_ENH;
			nand_host_pkg::op_reset:      code1 = nand_host_pkg::CMD_RESET;
			default:                      code1 = nand_host_pkg::CMD_READ;
		endcase
	endfunction

	function automatic logic [7:0] conf(input nand_host_pkg::op_e op,
		input nand_host_pkg::fin_e fin);
		case (op)
			nand_host_pkg::op_read:         conf = nand_host_pkg::CONF_READ;
			nand_host_pkg::op_read_copy:    conf = nand_host_pkg::CONF_COPY;
			nand_host_pkg::op_read_copy_sp: conf = nand_host_pkg::CONF_COPY_SP;
			nand_host_pkg::op_cache_rand:   conf = nand_host_pkg::CMD_CACHE;
			nand_host_pkg::op_erase:
				conf = (fin == nand_host_pkg::fin_plane) ?
					nand_host_pkg::CONF_ERASE_PL : nand_host_pkg::CONF_ERASE;
			default: begin
				case (fin)
					nand_host_pkg::fin_cache: conf = nand_host_pkg::CONF_PROG_CACHE;
					nand_host_pkg::fin_plane: conf = nand_host_pkg::CONF_PLANE;
					default:                  conf = nand_host_pkg::CONF_PROG;
				endcase
			end
		endcase
	endfunction

	function automatic logic is_read(input nand_host_pkg::op_e op);
		is_read = op inside {nand_host_pkg::op_read, nand_host_pkg::op_read_copy,
			nand_host_pkg::op_read_copy_sp, nand_host_pkg::op_cache_rand};
	endfunction

	function automatic logic is_prog(input nand_host_pkg::op_e op);
		is_prog = op inside {nand_host_pkg::op_prog, nand_host_pkg::op_prog2_trad,
			nand_host_pkg::op_copy_prog};
	endfunction

	function automatic logic row_only(input nand_host_pkg::op_e op);
		row_only = op inside {nand_host_pkg::op_erase,
			nand_host_pkg::op_status_enh};
	endfunction

	// status commands read at once, everything else waits for ready except program and erase sent with fin_none
	function automatic logic no_wait(input nand_host_pkg::op_e op);
		no_wait = op inside {nand_host_pkg::op_status,
			nand_host_pkg::op_status_enh};
	endfunction

	// ==========================================================
	// sequencer
	typedef enum logic [2:0] {
		st_idle, st_cmd1, st_addr, st_wdata, st_cmd2, st_wait_wb,
		st_wait_rdy, st_rdata
	} state_e;

	state_e                            state_reg, state_next;
	logic [7:0]                        cnt_reg, cnt_next;
	logic [nand_host_pkg::IDX_W-1:0]   idx_reg, idx_next;
	nand_host_pkg::op_e                op_reg, op_next;
	nand_host_pkg::fin_e               fin_reg, fin_next;
	logic [COL_W-1:0]                  col_reg, col_next;
	logic [ROW_W-1:0]                  row_reg, row_next;
	logic [LEN_W-1:0]                  left_reg, left_next;
	logic                              bus_end, take, has_conf;
	logic [nand_host_pkg::IO_W-1:0]    fmt_word;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 8'h01;
		idx_next   = idx_reg;
		op_next    = op_reg;
		fin_next   = fin_reg;
		col_next   = col_reg;
		row_next   = row_reg;
		left_next  = left_reg;
		take       = 1'b0;
		bus_end    = cnt_reg == nand_host_pkg::CYC_LAST;
		has_conf   = is_read(op_reg) ||
			((is_prog(op_reg) || op_reg == nand_host_pkg::op_erase) &&
			fin_reg != nand_host_pkg::fin_none);
		case (state_reg)
			st_idle: begin
				cnt_next = '0;
				if (req_valid) begin
					state_next = st_cmd1;
					op_next    = req_op;
					fin_next   = req_fin;
					col_next   = req_col;
					row_next   = req_row;
					left_next  = req_len;
				end
			end
			st_cmd1: begin
				if (bus_end) begin
					cnt_next = '0;
					if (is_read(op_reg) || is_prog(op_reg) ||
						row_only(op_reg)) begin
						state_next = st_addr;
						idx_next   = row_only(op_reg) ?
							nand_host_pkg::ROW_START : '0;
					end else if (!no_wait(op_reg)) begin
						state_next = st_wait_wb;
					end else begin
						state_next = (left_reg != '0) ? st_rdata : st_idle;
					end
				end
			end
			st_addr: begin
				if (bus_end) begin
					cnt_next = '0;
					idx_next = idx_reg + 3'h1;
					// all address cycles are sent, only the three row cycles for erase and enhanced status
					if (idx_reg == 3'(ADDR_CYCLES - 1)) begin
						if (is_prog(op_reg) && left_reg != '0) begin
							state_next = st_wdata;
						end else if (has_conf) begin
							state_next = st_cmd2;
						end else if (no_wait(op_reg)) begin
							state_next = (left_reg != '0) ? st_rdata : st_idle;
						end else begin
							state_next = st_idle;
						end
					end
				end
			end
			st_wdata: begin
				// idle before the strobe until the user has a word
				if (cnt_reg == '0 && !wr_valid) begin
					cnt_next = '0;
				end else begin
					take = cnt_reg == '0;
					if (bus_end) begin
						cnt_next  = '0;
						left_next = left_reg - 1'b1;
						if (left_reg == LEN_W'(1)) begin
							state_next = has_conf ? st_cmd2 : st_idle;
						end
					end
				end
			end
			st_cmd2: begin
				if (bus_end) begin
					cnt_next   = '0;
					state_next = st_wait_wb;
				end
			end
			st_wait_wb: begin
				// ready/busy is not valid right after the confirm
				if (cnt_reg == nand_host_pkg::WB_CYC - 8'h01) begin
					cnt_next   = '0;
					state_next = st_wait_rdy;
				end
			end
			st_wait_rdy: begin
				cnt_next = '0;
				if (rb_n_in) begin
					state_next = (is_read(op_reg) ||
						op_reg == nand_host_pkg::op_cache_seq ||
						op_reg == nand_host_pkg::op_cache_end) &&
						left_reg != '0 ? st_rdata : st_idle;
				end
			end
			st_rdata: begin
				if (bus_end) begin
					cnt_next  = '0;
					left_next = left_reg - 1'b1;
					if (left_reg == LEN_W'(1)) begin
						state_next = st_idle;
					end
				end
			end
			default: state_next = st_idle;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= st_idle;
			cnt_reg   <= '0;
			idx_reg   <= '0;
			op_reg    <= nand_host_pkg::op_read;
			fin_reg   <= nand_host_pkg::fin_end;
			col_reg   <= '0;
			row_reg   <= '0;
			left_reg  <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			idx_reg   <= idx_next;
			op_reg    <= op_next;
			fin_reg   <= fin_next;
			col_reg   <= col_next;
			row_reg   <= row_next;
			left_reg  <= left_next;
		end
	end

	// word for the address cycle in idx_reg, one register behind idx_next
	addr_cycle_fmt #(
		.COL_W    (COL_W),
		.ROW_W    (ROW_W)
	) u_fmt (
		.core_clk (core_clk),
		.srst     (srst),
		.idx      (idx_next),
		.x16      (bus_x16),
		.col      (col_next),
		.row      (row_next),
		.word_reg (fmt_word)
	);

	// ==========================================================
	// pin drivers, taken from the next sequencer state, wp_n from wp_release
	logic                           drive, strobe_lo, cle_next, ale_next;
	logic                           ce_n_next, we_n_next, re_n_next;
	logic                           oe_next, take_next, rdv_next, done_next;
	logic [nand_host_pkg::IO_W-1:0] io_next, rd_next, lane_mask;

	always_comb begin
		drive     = state_next inside {st_cmd1, st_addr, st_wdata, st_cmd2};
		strobe_lo = cnt_next >= 8'h01 && cnt_next <= nand_host_pkg::LOW_CYC;
		lane_mask = bus_x16 ? '1 : 16'h00ff; // upper lines unused on x8
		cle_next  = state_next inside {st_cmd1, st_cmd2};
		ale_next  = state_next == st_addr;
		ce_n_next = !(drive || state_next == st_rdata);
		// strobes stay high outside their own phases, busy waits included
		we_n_next = !(drive && strobe_lo);
		re_n_next = !(state_next == st_rdata && strobe_lo);
		oe_next   = drive;
		io_next   = io_out_reg;
		case (state_next)
			st_cmd1: io_next = {8'h00, code1(op_next)};
			st_cmd2: io_next = {8'h00, conf(op_next, fin_next)};
			st_addr: io_next = fmt_word;
			st_wdata: begin
				if (take) begin
					io_next = wr_data & lane_mask;
				end
			end
			default: io_next = io_out_reg;
		endcase
		take_next = take;
		rdv_next  = state_reg == st_rdata &&
			cnt_reg == nand_host_pkg::LOW_CYC;
		rd_next   = rdv_next ? (io_in & lane_mask) : rd_data_reg;
		done_next = state_reg != st_idle && state_next == st_idle;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			req_ready_reg     <= 1'b0;
			wr_take_reg       <= 1'b0;
			rd_data_reg       <= '0;
			rd_valid_reg      <= 1'b0;
			done_reg          <= 1'b0;
			cle_reg           <= 1'b0;
			ale_reg           <= 1'b0;
			ce_n_reg          <= 1'b1;
			we_n_reg          <= 1'b1;
			read_strobe_n_reg <= 1'b1;
			wp_n_reg          <= 1'b0;
			io_out_reg        <= '0;
			io_oe_reg         <= 1'b0;
		end else begin
			req_ready_reg     <= state_next == st_idle;
			wr_take_reg       <= take_next;
			rd_data_reg       <= rd_next;
			rd_valid_reg      <= rdv_next;
			done_reg          <= done_next;
			cle_reg           <= cle_next;
			ale_reg           <= ale_next;
			ce_n_reg          <= ce_n_next;
			we_n_reg          <= we_n_next;
			read_strobe_n_reg <= re_n_next;
			wp_n_reg          <= wp_release;
			io_out_reg        <= io_next;
			io_oe_reg         <= oe_next;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	logic cmd_rise, cmd1_rise, we_n_prev_reg, we_n_prev_next;

	// write strobe one cycle back, reset to its idle high level so that
	// leaving reset never looks like a latch edge
	always_comb begin
		we_n_prev_next = we_n_reg;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			we_n_prev_reg <= 1'b1;
		end else begin
			we_n_prev_reg <= we_n_prev_next;
		end
	end

	// command byte latched by the device at this strobe rise
	assign cmd_rise  = we_n_reg && !we_n_prev_reg && cle_reg;
	assign cmd1_rise = cmd_rise && state_reg == st_cmd1;

	chk_busy_strobes: assert property (
		state_reg == st_wait_rdy |-> we_n_reg && read_strobe_n_reg)
		else $error("strobe low while waiting for ready");
	chk_addr_upper: assert property (
		$rose(we_n_reg) && ale_reg && !bus_x16 |-> io_out_reg[15:8] == '0)
		else $error("address cycle drives upper lines on x8");
	chk_addr_count: assert property (
		state_reg == st_addr && state_next != st_addr |->
		idx_reg == 3'(ADDR_CYCLES - 1))
		else $error("address phase left with wrong cycle count");
	chk_read_conf: assert property (
		cmd_rise && state_reg == st_cmd2 && op_reg == nand_host_pkg::op_read
		|-> io_out_reg[7:0] == nand_host_pkg::CONF_READ)
		else $error("page read not confirmed by 30h");
	chk_prog_cache: assert property (
		cmd_rise && state_reg == st_cmd2 && op_reg == nand_host_pkg::op_prog &&
		fin_reg == nand_host_pkg::fin_cache
		|-> io_out_reg[7:0] == nand_host_pkg::CONF_PROG_CACHE)
		else $error("cache program not confirmed by 15h");
	chk_plane_conf: assert property (
		cmd_rise && state_reg == st_cmd2 && is_prog(op_reg) &&
		fin_reg == nand_host_pkg::fin_plane
		|-> io_out_reg[7:0] == nand_host_pkg::CONF_PLANE)
		else $error("first plane not closed by 11h");
	chk_copy_start: assert property (
		cmd1_rise && op_reg == nand_host_pkg::op_copy_prog
		|-> io_out_reg[7:0] == nand_host_pkg::CMD_COPY)
		else $error("copy program not opened by 85h");
	chk_erase_seq: assert property (
		cmd1_rise && op_reg == nand_host_pkg::op_erase
		|-> io_out_reg[7:0] == nand_host_pkg::CMD_ERASE ##1
		(!ale_reg)[*2] ##[1:40] ale_reg)
		else $error("erase not opened by 60h and address");
	chk_cache_end: assert property (
		cmd1_rise && op_reg == nand_host_pkg::op_cache_end
		|-> io_out_reg[7:0] == nand_host_pkg::CMD_CACHE_END)
		else $error("cache read not ended by 3fh");

	cov_read_done: cover property (
		rd_valid_reg && op_reg == nand_host_pkg::op_read ##[1:20] done_reg);
	cov_prog_done: cover property (
		state_reg == st_wait_rdy && op_reg == nand_host_pkg::op_prog ##1
		done_reg);
	cov_erase_plane: cover property (
		cmd_rise && op_reg == nand_host_pkg::op_erase &&
		fin_reg == nand_host_pkg::fin_plane);
	cov_status_read: cover property (
		rd_valid_reg && op_reg == nand_host_pkg::op_status);
endmodule

/* testbench/flash_dev_model.sv */
// behavioural flash device seen from the host controller pins
`timescale 1ns/1ps
module flash_dev_model #(
	parameter int BUSY_NS = 400
) (
	input  wire logic        cle,
	input  wire logic        ale,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        read_strobe_n,
	input  wire logic        wp_n,
	input  wire logic [15:0] io,
	output logic      [15:0] dev_data,
	output logic             dev_oe,
	output logic             busy
);
	// ====================
	// logs the bench inspects after each request
	logic [15:0] cmd_q[$];
	logic [15:0] adr_q[$];
	logic [15:0] dat_q[$];
	logic [11:0] col_cnt = 12'h000;
	logic        fail = 1'b0;
	logic        stat_mode = 1'b0;
	logic        rd_busy = 1'b0;
	int          viol = 0;
	event        go_busy;
	initial busy = 1'b0;
	initial dev_data = 16'h0000;
	// outputs float unless selected and read strobe low
	assign dev_oe = !ce_n && !read_strobe_n;
	// ====================
	// latch on write strobe rise, ignored while deselected
	always @(posedge we_n) if (!ce_n) begin
		// busy device takes only reset and status
		if (cle && (!busy || io[7:0] inside {8'hff, 8'h70, 8'h78})) begin
			cmd_q.push_back(io);
			stat_mode = io[7:0] inside {8'h70, 8'h78};
			if (io[7:0] inside {8'h00, 8'h60, 8'h80, 8'h81, 8'h85})
				adr_q.delete(); // opening code restarts decoding
			if (io[7:0] == 8'h80)
				fail = 1'b0;
			// protected part never starts a modify
			if (io[7:0] inside {8'h10, 8'h15, 8'h11, 8'hd0, 8'hd1} && !wp_n)
				fail = 1'b1;
			else if (io[7:0] inside {8'h30, 8'h31, 8'h35, 8'h36, 8'h3f,
				8'h10, 8'h15, 8'h11, 8'hd0, 8'hd1, 8'hff}) begin
				rd_busy = io[7:0] inside {8'h30, 8'h31, 8'h35, 8'h36, 8'h3f};
				-> go_busy;
			end
		end else if (ale && !busy) begin
			adr_q.push_back(io);
			// column first, row bits follow
			if (adr_q.size() == 1)
				col_cnt[7:0] = io[7:0];
			if (adr_q.size() == 2)
				col_cnt[11:8] = io[3:0];
		end else if (!cle && !ale && !busy)
			dat_q.push_back(io);
	end
	// busy pulls the open-drain line low; a retrigger mid-busy is lost
	always @(go_busy) begin
		busy = 1'b1;
		#BUSY_NS busy = 1'b0;
		rd_busy = 1'b0;
	end
	// strobes moving in read busy are counted as faults of the host
	always @(negedge we_n or negedge read_strobe_n)
		if (busy && rd_busy && !ce_n)
			viol++;
	// read strobe fall puts out a word and steps the column
	always @(negedge read_strobe_n) if (!ce_n) begin
		dev_data = stat_mode ? {9'h001, !busy, 5'h00, fail} :
			{col_cnt[7:0], ~col_cnt[7:0]};
		col_cnt = col_cnt + 12'h001;
	end
endmodule

/* testbench/nand_host_ctrl_tb_top.sv */
// bench top: host controller against the flash device model
`timescale 1ns/1ps
module nand_host_ctrl_tb_top;
	// ====================
	// op, fin, first code, last code for each command form but 00h-30h read, 80h-10h program and 70h status
	localparam logic [23:0] TBL [15] = '{24'h100035, 24'h200036,
		24'h300031, 24'h403131, 24'h503f3f, 24'h618015, 24'h628011,
		24'h708110, 24'h828511, 24'h808510, 24'h9260d1, 24'h936060,
		24'h9060d0, 24'hb07878, 24'hc0ffff};
	logic                core_clk = 1'b0;
	logic                srst = 1'b1;
	logic                req_valid = 1'b0;
	nand_host_pkg::op_e  req_op = nand_host_pkg::op_read;
	nand_host_pkg::fin_e req_fin = nand_host_pkg::fin_end;
	logic [11:0]         req_col = 12'h000;
	logic [18:0]         req_row = 19'h00000;
	logic [12:0]         req_len = 13'h0000;
	logic                bus_x16 = 1'b0;
	logic                wp_release = 1'b0;
	logic [15:0]         wr_data = 16'h0012;
	logic [15:0]         last_io = 16'h0000;
	logic [15:0]         io_in, io_out, dev_data, rd_data;
	logic                req_ready, wr_take, rd_valid, done, cle, ale;
	logic                ce_n, we_n, re_n, wp_n, io_oe, dev_oe, busy;
	logic [15:0]         rd_q[$];
	int                  error_cnt = 0;
	int                  compares = 0;
	always #2 core_clk = ~core_clk;
	// undriven bus shows the inverse of its last value, never a stale copy
	assign io_in = io_oe ? io_out : (dev_oe ? dev_data : ~last_io);
	always @(posedge core_clk) last_io <= io_in;
	// ====================
	// next write word after each take; read words collected
	always @(posedge core_clk) begin
		if (wr_take === 1'b1)
			wr_data <= wr_data + 16'h0111;
		if (rd_valid === 1'b1)
			rd_q.push_back(rd_data);
	end
	nand_host_ctrl u_nand_host_ctrl (.core_clk(core_clk), .srst(srst),
		.req_valid(req_valid), .req_ready_reg(req_ready), .req_op(req_op),
		.req_fin(req_fin), .req_col(req_col), .req_row(req_row),
		.req_len(req_len), .bus_x16(bus_x16), .wp_release(wp_release),
		.wr_data(wr_data), .wr_valid(1'b1), .wr_take_reg(wr_take),
		.rd_data_reg(rd_data), .rd_valid_reg(rd_valid), .done_reg(done),
		.cle_reg(cle), .ale_reg(ale), .ce_n_reg(ce_n), .we_n_reg(we_n),
		.read_strobe_n_reg(re_n), .wp_n_reg(wp_n), .io_out_reg(io_out),
		.io_oe_reg(io_oe), .io_in(io_in), .rb_n_in(~busy));
	flash_dev_model u_flash_dev_model (.cle(cle), .ale(ale), .ce_n(ce_n),
		.we_n(we_n), .read_strobe_n(re_n), .wp_n(wp_n), .io(io_in),
		.dev_data(dev_data), .dev_oe(dev_oe), .busy(busy));
	// ====================
	// shared compare, request and verdict tasks
	task automatic cmp(input logic [15:0] got, exp, input string what);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cmp_adr(input logic [79:0] exp);
		for (int i = 0; i < 5; i++)
			cmp(u_flash_dev_model.adr_q[i], exp[79-16*i -: 16], "address");
	endtask
	task automatic run(input logic [3:0] op, input logic [1:0] fin,
		input logic [11:0] col, input logic [18:0] row, input logic [12:0] len);
		int n;
		n = 0;
		u_flash_dev_model.cmd_q.delete();
		u_flash_dev_model.dat_q.delete();
		rd_q.delete();
		do @(negedge core_clk); while (req_ready !== 1'b1);
		@(posedge core_clk);
		req_op <= nand_host_pkg::op_e'(op);
		req_fin <= nand_host_pkg::fin_e'(fin);
		req_col <= col;
		req_row <= row;
		req_len <= len;
		req_valid <= 1'b1;
		@(posedge core_clk);
		req_valid <= 1'b0;
		do begin
			@(negedge core_clk);
			n++;
		end while (done !== 1'b1 && n < 4000);
		cmp({15'h0000, done}, 16'h0001, "request never finished");
	endtask
	task automatic close_out();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ====================
	// scenarios
	task automatic t_reset();
		repeat (11) @(posedge core_clk);
		@(negedge core_clk);
		cmp({11'h000, wp_n, ce_n, we_n, re_n, io_oe}, 16'h000e, "idle pins");
		@(posedge core_clk);
		srst <= 1'b0;
	endtask
	task automatic t_read();
		run(4'h0, 2'h0, 12'h5a3, 19'h4bc2d, 13'h0002);
		cmp(u_flash_dev_model.cmd_q[0], 16'h0000, "read open");
		cmp(u_flash_dev_model.cmd_q[1], 16'h0030, "read confirm");
		cmp_adr(80'h00a3_0005_002d_00bc_0004);
		cmp(rd_q[0], 16'h005c, "first read word");
		cmp(rd_q[1], 16'h005b, "second read word");
	endtask
	task automatic t_x16();
		@(posedge core_clk);
		bus_x16 <= 1'b1;
		run(4'h0, 2'h0, 12'h6c5, 19'h71234, 13'h0001);
		cmp_adr(80'h00c5_0006_0034_0012_0007);
		cmp(rd_q[0], 16'hc53a, "wide read word");
		@(posedge core_clk);
		bus_x16 <= 1'b0;
	endtask
	task automatic t_prog();
		@(posedge core_clk);
		wp_release <= 1'b1;
		run(4'h6, 2'h0, 12'h010, 19'h00041, 13'h0002);
		cmp(u_flash_dev_model.cmd_q[1], 16'h0010, "program confirm");
		cmp(u_flash_dev_model.dat_q[0], 16'h0012, "first data");
		cmp(u_flash_dev_model.dat_q[1], 16'h0023, "second data");
		run(4'ha, 2'h0, 12'h000, 19'h00000, 13'h0001);
		cmp(rd_q[0], 16'h00c0, "status ready and pass");
		@(posedge core_clk);
		wp_release <= 1'b0;
		run(4'h6, 2'h0, 12'h010, 19'h00041, 13'h0001);
		cmp({15'h0000, wp_n}, 16'h0000, "protect pin low");
		run(4'ha, 2'h0, 12'h000, 19'h00000, 13'h0001);
		cmp(rd_q[0], 16'h00c1, "status after refusal");
	endtask
	task automatic t_codes();
		@(posedge core_clk);
		wp_release <= 1'b1;
		foreach (TBL[i]) begin
			run(TBL[i][23:20], TBL[i][17:16], 12'h001, 19'h00200, 13'h0001);
			cmp(u_flash_dev_model.cmd_q[0], {8'h00, TBL[i][15:8]}, "opening");
			cmp(u_flash_dev_model.cmd_q[$], {8'h00, TBL[i][7:0]}, "closing");
		end
	endtask
	// ====================
	// main sequence and watchdog
	initial begin
		t_reset();
		t_read();
		t_x16();
		t_prog();
		t_codes();
		cmp(16'(u_flash_dev_model.viol), 16'h0000, "strobes in busy");
		close_out();
	end
	initial begin
		#200000;
		error_cnt++;
		$display("FAIL %0t watchdog expired", $time);
		close_out();
	end
endmodule
